// File: hw/dcass_seq.sv
// How it works
// - track input for first three serial clocks
// - hold and convert clocks four to sixteen
// - chip select low interval is one frame
// - drive data output only while selected
// - result shifts out most significant first
// - capture next channel address every conversion
// - power down when deselected or between conversions
// - sample taken at fourth falling serial edge
// - each conversion spans exactly sixteen clocks
// - sequencing runs only from serial clock
// - track connects capacitor to selected channel
// - data input sampled first seven rising edges
// - result bits begin on fifth serial clock
// - address bits five-three, bit three picks channel
// - first conversion after power-up is input one
module dcass_seq
    import dcass_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic              clk_sys,        // system clock
    input  wire logic              rst,            // async reset, high
    input  wire logic              sclk,           // serial clock from host
    input  wire logic              cs_n,           // chip select, low
    input  wire logic              din,            // serial data in
    input  wire logic              cmp_above,      // comparator: input>=dac
    output logic                   dout,           // serial data out
    output logic                   dout_oe,        // data out enable
    output logic                   sample_switch,  // 1: cap on input
    output logic                   comparator_balance_switch, // 1: balanced
    output logic                   analog_input_two_sel, // mux select
    output logic [RES_W-1:0]       dac_code,       // trial code to dac
    output logic                   power_down,     // analog power down
    output logic                   res_valid,      // result word valid
    output logic [RES_W:0]         res_data,       // {channel, code}
    input  wire logic              res_ready,      // user takes word
    output logic                   buf_full,       // buffer full
    output logic                   res_ovf,        // word lost, sticky
    input  wire logic              res_ovf_clr     // clear lost flag
);

    ////////////////////////////////////////////////////////////////////
    // serial clock domain

    // frame position
    logic             frame_clr;
    logic [4:0]       fcnt_r;
    logic [3:0]       rcnt_r;
    logic [3:0]       bit_idx;
    logic             in_conv;

    // control byte and channel select
    logic [CTRL_W-2:0] din_sh_r;
    logic             next_ch_r;
    logic             conv_ch_r;

    // approximation register
    logic [RES_W-1:0] sar_r;
    logic [RES_W-1:0] sar_nxt;

    // pin and switch registers
    logic             dout_r;
    logic             dout_oe_r;
    logic             sample_r;
    logic             balance_r;
    logic             pdown_r;

    // finished word for the system side
    logic [RES_W:0]   res_word_r;
    logic             res_tgl_r;

    // deselect ends the frame and clears frame state at once
    assign frame_clr = cs_n | rst;
    assign in_conv   = (fcnt_r >= FCNT_HOLD) && (fcnt_r < FCNT_LAST);
    assign bit_idx   = 4'(FCNT_BITTOP - fcnt_r);

    ////////////////////////////////////////////////////////////////////

    // falling-edge counter, wraps every sixteen clocks
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            fcnt_r <= FCNT_RST;
        end else if (fcnt_r == FCNT_LAST) begin
            fcnt_r <= FCNT_ONE;
        end else begin
            fcnt_r <= fcnt_r + FCNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // rising-edge counter for control byte capture
    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            rcnt_r <= RCNT_RST;
        end else begin
            rcnt_r <= rcnt_r + RCNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // control byte bits, one per rising edge

    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            din_sh_r <= '0;
        end else if (rcnt_r < RCNT_BYTE) begin
            din_sh_r <= {din_sh_r[CTRL_W-3:0], din};
        end
    end

    ////////////////////////////////////////////////////////////////////

    // channel for the following conversion, taken at the eighth bit
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            next_ch_r <= CH_RST;
        end else if (rcnt_r == RCNT_BYTE) begin
            // bit2 ignored, bit1 high is forbidden
            next_ch_r <= din_sh_r[ADDR_BIT0-1];
        end
    end

    ////////////////////////////////////////////////////////////////////

    // channel latched when track starts
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            conv_ch_r <= CH_RST;
        end else if (fcnt_r == FCNT_RST || fcnt_r == FCNT_LAST) begin
            conv_ch_r <= next_ch_r;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // track/hold switches and power state
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            sample_r  <= 1'b0;
            balance_r <= 1'b0;
            pdown_r   <= 1'b1;
        end else if (fcnt_r == FCNT_RST || fcnt_r == FCNT_LAST) begin
            sample_r  <= 1'b1;
            balance_r <= 1'b1;
            pdown_r   <= 1'b0;
        end else if (fcnt_r == FCNT_HOLD - FCNT_ONE) begin
            sample_r  <= 1'b0;
            balance_r <= 1'b0;
        end else if (fcnt_r == FCNT_BITTOP) begin
            pdown_r   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // successive approximation: decide current bit, try next one
    always_comb begin
        sar_nxt = sar_r;
        for (int j = 0; j < RES_W; j++) begin
            if (j == int'(bit_idx)) begin
                sar_nxt[j] = cmp_above;
            end else if (j + 1 == int'(bit_idx)) begin
                sar_nxt[j] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////

    // trial code register, loaded with the top bit at hold
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            sar_r <= SAR_RST;
        end else if (fcnt_r == FCNT_HOLD - FCNT_ONE) begin
            sar_r <= SAR_TRIAL;
        end else if (in_conv) begin
            sar_r <= sar_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // serial output: zeros until fifth clock, then decided bits
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            dout_r    <= 1'b0;
            dout_oe_r <= 1'b0;
        end else begin
            dout_oe_r <= 1'b1;
            if (in_conv) begin
                dout_r <= cmp_above;
            end else begin
                dout_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////

    // finished word held until the next one; toggle flags it
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            res_word_r <= '0;
            res_tgl_r  <= 1'b0;
        end else if (fcnt_r == FCNT_BITTOP) begin
            res_word_r <= {conv_ch_r, sar_nxt};
            res_tgl_r  <= ~res_tgl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // link side outputs, all straight from flops
    assign dout                      = dout_r;
    assign dout_oe                   = dout_oe_r;
    assign sample_switch             = sample_r;
    assign comparator_balance_switch = balance_r;
    assign analog_input_two_sel      = conv_ch_r;
    assign dac_code                  = sar_r;
    assign power_down                = pdown_r;

    ////////////////////////////////////////////////////////////////////
    // system clock domain: crossing

    // toggle synchroniser, third flop only for the edge
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;

    // one-cycle write request into the buffer
    logic push;

    // two flops into this domain before the edge detect
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= res_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // word is stable for a whole conversion after the toggle
    assign push = tgl_s2_r ^ tgl_s3_r;

    ////////////////////////////////////////////////////////////////////
    // result buffer, head entry drives the output

    // occupancy counter wide enough to reach DEPTH
    localparam int CW = $clog2(DEPTH + 1);

    logic [RES_W:0] mem_r [DEPTH];
    logic [CW-1:0]  cnt_r;
    logic [CW-1:0]  cnt_nxt;
    logic           pop;
    logic           wr;
    logic           valid_r;
    logic           full_r;
    logic           ovf_r;

    // a pop frees room for a write in the same cycle
    assign pop = valid_r & res_ready;
    assign wr  = push & (~full_r | pop);

    ////////////////////////////////////////////////////////////////////

    // next occupancy
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !wr) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////

    // entries shift toward the head on a pop
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    mem_r[i] <= '0;
                end else if (pop) begin
                    if (wr && i + 1 == int'(cnt_r)) begin
                        mem_r[i] <= res_word_r;
                    end else if (i + 1 < DEPTH) begin
                        mem_r[i] <= mem_r[(i + 1) % DEPTH];
                    end
                end else if (wr && i == int'(cnt_r)) begin
                    mem_r[i] <= res_word_r;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////

    // occupancy and the flags derived from it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r   <= '0;
            valid_r <= 1'b0;
            full_r  <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            valid_r <= (cnt_nxt != '0);
            full_r  <= (cnt_nxt == CW'(DEPTH));
        end
    end

    ////////////////////////////////////////////////////////////////////

    // lost word flag; a new loss wins over the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovf_r <= 1'b0;
        end else if (push && !wr) begin
            ovf_r <= 1'b1;
        end else if (res_ovf_clr) begin
            ovf_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // system side outputs, all straight from flops
    assign res_valid = valid_r;
    assign res_data  = mem_r[0];
    assign buf_full  = full_r;
    assign res_ovf   = ovf_r;

endmodule

// File: hw/dcass_pkg.sv
package dcass_pkg;
    // falling-edge count values within one conversion
    localparam logic [4:0] FCNT_RST    = 5'h00;
    localparam logic [4:0] FCNT_TRACK  = 5'h01;
    localparam logic [4:0] FCNT_HOLD   = 5'h04;
    localparam logic [4:0] FCNT_LAST   = 5'h10;
    localparam logic [4:0] FCNT_ONE    = 5'h01;
    localparam logic [4:0] FCNT_BITTOP = 5'h0F;
    // rising-edge count values
    localparam logic [3:0] RCNT_RST    = 4'h0;
    localparam logic [3:0] RCNT_ONE    = 4'h1;
    localparam logic [3:0] RCNT_BYTE   = 4'h7;
    // control byte layout
    localparam int         CTRL_W      = 8;
    localparam int         ADDR_BIT2   = 5;
    localparam int         ADDR_BIT1   = 4;
    localparam int         ADDR_BIT0   = 3;
    // result word
    localparam int         RES_W       = 12;
    localparam logic [11:0] SAR_RST    = 12'h000;
    localparam logic [11:0] SAR_TRIAL  = 12'h800;
    localparam logic       CH_RST      = 1'b0;
    localparam int         BUF_DEPTH   = 2;
endpackage

// File: verification/dcass_seq_monitor.sv
module dcass_seq_monitor
    import dcass_pkg::*;
(
    input wire logic             clk_sys,    // clock
    input wire logic             rst,        // reset
    input wire logic             sclk,       // link
    input wire logic             cs_n,       // frame
    input wire logic             dout,       // data
    input wire logic             dout_oe,    // enable
    input wire logic             sample_switch,             // track
    input wire logic             comparator_balance_switch, // bal
    input wire logic [RES_W-1:0] dac_code,   // trial
    input wire logic             power_down  // idle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] fcnt_r;
    logic       trk;
    ////////////////////////////////////////
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) fcnt_r <= FCNT_RST;
        else if (fcnt_r == FCNT_LAST) fcnt_r <= FCNT_ONE;
        else fcnt_r <= fcnt_r + FCNT_ONE;
    end
    assign trk = sample_switch && comparator_balance_switch;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_to_hold;
        fcnt_r == 5'h03 ##1 fcnt_r == FCNT_HOLD;
    endsequence
    property p_track;
        fcnt_r inside {[FCNT_TRACK:5'h03]} |-> trk;
    endproperty
    a_track: assert property (p_track) else $error("no track");
    property p_hold;
        fcnt_r >= FCNT_HOLD |-> !sample_switch && !comparator_balance_switch;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold");
    property p_sample;
        s_to_hold |-> !trk && dac_code == SAR_TRIAL;
    endproperty
    a_sample: assert property (p_sample) else $error("bad sample");
    property p_oe;
        cs_n |-> !dout_oe && power_down;
    endproperty
    a_oe: assert property (p_oe) else $error("driven idle");
    property p_run;
        fcnt_r inside {[FCNT_ONE:FCNT_BITTOP]} |-> dout_oe && !power_down;
    endproperty
    a_run: assert property (p_run) else $error("not powered");
    property p_gap;
        fcnt_r == FCNT_LAST |-> power_down && dout_oe;
    endproperty
    a_gap: assert property (p_gap) else $error("gap powered");
    property p_lead;
        fcnt_r inside {[FCNT_ONE:FCNT_HOLD]} |-> !dout;
    endproperty
    a_lead: assert property (p_lead) else $error("early bit");
    property p_bits;
        fcnt_r > FCNT_HOLD |-> dout == dac_code[4'(FCNT_LAST - fcnt_r)];
    endproperty
    a_bits: assert property (p_bits) else $error("bit order");
endmodule
bind dcass_seq dcass_seq_monitor u_mon (.clk_sys, .rst, .sclk, .cs_n, .dout,
    .dout_oe, .sample_switch, .comparator_balance_switch, .dac_code,
    .power_down);

// File: verification/dcass_host_model.sv
module dcass_host_model (
    output logic             sclk,      // link clock
    output logic             cs_n,      // frame
    output logic             din,       // byte out
    output logic             cmp_above, // comparator
    input  wire logic        dout,      // word in
    input  wire logic        dout_oe,   // word enable
    input  wire logic        sample_switch,        // track
    input  wire logic        analog_input_two_sel, // mux
    input  wire logic [11:0] dac_code,  // trial
    input  wire logic [11:0] vin_one,   // level one
    input  wire logic [11:0] vin_two    // level two
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] held = 12'h000;
    logic [11:0] got [2];
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    always @(negedge sample_switch) begin
        held = analog_input_two_sel ? vin_two : vin_one;
    end
    assign cmp_above = held >= dac_code;
    // n conversions, byte c in ctl[8c+7:8c]
    task automatic frame(input int n, input logic [15:0] ctl);
        #7 cs_n = 1'b0;
        for (int c = 0; c < n; c++) begin
            for (int k = 0; k < 16; k++) begin
                #40 sclk = 1'b0;
                din = (k < 8) ? ctl[8*c+7-k] : ~din;
                #40 sclk = 1'b1;
                if (k > 3) got[c] = {got[c][10:0], dout_oe ? dout : 1'bx};
            end
        end
        #40 cs_n = 1'b1;
        din = ~din;
    endtask
endmodule

// File: verification/tb.sv
module tb;
    import dcass_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        res_ready = 1'b0;
    logic        res_ovf_clr = 1'b0;
    logic        sclk, cs_n, din, cmp_above, dout, dout_oe, power_down;
    logic        sample_switch, comparator_balance_switch, res_ovf;
    logic        analog_input_two_sel, res_valid, buf_full;
    logic [11:0] dac_code;
    logic [11:0] vin_one = 12'hA5C;
    logic [11:0] vin_two = 12'h3C1;
    logic [12:0] res_data;
    int          bad_count = 0;
    int          comparisons = 0;
    always #10 clk_sys = ~clk_sys;
    dcass_seq dut (.clk_sys, .rst, .sclk, .cs_n, .din, .cmp_above, .dout,
        .dout_oe, .sample_switch, .comparator_balance_switch, .dac_code,
        .analog_input_two_sel, .power_down, .res_valid, .res_data,
        .res_ready, .buf_full, .res_ovf, .res_ovf_clr);
    dcass_host_model host (.sclk, .cs_n, .din, .cmp_above, .dout, .dout_oe,
        .sample_switch, .analog_input_two_sel, .dac_code, .vin_one, .vin_two);
    ////////////////////////////////////////
    task automatic chk(string what, logic [12:0] exp, logic [12:0] seen);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic take(logic [12:0] exp);
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk("valid", 13'h1, {12'h000, res_valid});
        chk("word", exp, res_data);
        res_ready = 1'b1;
        @(negedge clk_sys);
        res_ready = 1'b0;
    endtask
    task automatic t_first();
        chk("idle", 13'h1, {dout_oe, res_valid, res_ovf, power_down});
        host.frame(1, 16'h0008);
        chk("dout", {1'b0, vin_one}, {1'b0, host.got[0]});
        take({1'b0, vin_one});
        $display("test first done");
    endtask
    task automatic t_b2b();
        host.frame(2, 16'hE728);
        chk("dout0", {1'b1, vin_two}, {1'b1, host.got[0]});
        chk("dout1", {1'b1, vin_two}, {1'b1, host.got[1]});
        repeat (8) @(negedge clk_sys);
        chk("full", 13'h1, {12'h000, buf_full});
        $display("test back to back done");
    endtask
    task automatic t_ovf();
        host.frame(1, 16'h0000);
        chk("dout", {1'b0, vin_one}, {1'b0, host.got[0]});
        repeat (8) @(negedge clk_sys);
        chk("ovf", 13'h1, {12'h000, res_ovf});
        take({1'b1, vin_two});
        take({1'b1, vin_two});
        res_ovf_clr = 1'b1;
        @(negedge clk_sys);
        res_ovf_clr = 1'b0;
        @(negedge clk_sys);
        chk("drained", 13'h0, {11'h000, res_valid, res_ovf});
        $display("test overflow done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_first();
        t_b2b();
        t_ovf();
        end_sim();
    end
    initial begin
        #100us;
        bad_count++;
        end_sim();
    end
endmodule
